// ---- hw/tcb_regs.vh ----
/*
 constants for the 16-bit timer/counter base block.
 assumes plain Verilog-2005 and inclusion by bare name.
*/
`ifndef TCB_REGS_VH
`define TCB_REGS_VH
`define TCB_W 16
`define TCB_HALF 8
`define TCB_NCH 4
`define TCB_ZERO 16'h0000
`define TCB_MAX 16'hffff
`define TCB_BZERO 8'h00
`define TCB_BMAX 8'hff
`define TCB_PSC_W 10
`define TCB_PSC_N 11
`define TCB_CSEL_W 5
`define TCB_CSEL_OFF 5'h00
`define TCB_CSEL_PSC_LAST 5'h0b
`define TCB_CSEL_EV_BIT 4
`define TCB_EVR_NONE 2'h0
`define TCB_EVR_UPDOWN 2'h1
`define TCB_EVR_CAPTURE 2'h2
`define TCB_EV_N 8
`endif

// ---- hw/tcb_prescaler.v ----
/*
 shared prescaler: one-cycle ticks at clock divided by 2^k, k=0..10.
 assumes one synchronous clock and active-high synchronous reset.
*/
`timescale 1ns/100ps
`include "tcb_regs.vh"
module tcb_prescaler (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// tick outputs, bit k divides by 2^k
	output reg [`TCB_PSC_N-1:0] o_tick
);
	reg [`TCB_PSC_W-1:0] div_q;
	integer k;
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			div_q <= {`TCB_PSC_W{1'b0}};
			o_tick <= {`TCB_PSC_N{1'b0}};
		end else begin
			div_q <= div_q + {{(`TCB_PSC_W-1){1'b0}}, 1'b1};
			o_tick[0] <= 1'b1;
			for (k = 1; k < `TCB_PSC_N; k = k + 1) begin
				o_tick[k] <= &(~(~div_q << (`TCB_PSC_W - k)));
			end
		end
	end
endmodule

// ---- hw/tcb_channel.v ----
/*
 one compare/capture channel with staging register.
 assumes the counter, refresh and capture inputs come from the base.
*/
`timescale 1ns/100ps
`include "tcb_regs.vh"
module tcb_channel #(
	parameter PRESENT = 1
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// configuration
	input wire i_capture_mode,
	input wire i_double_buf,
	input wire i_enable,
	// base counter
	input wire [`TCB_W-1:0] i_cnt,
	input wire i_update,
	input wire i_capture,
	// software access
	input wire i_wr,
	input wire i_stg_wr,
	input wire i_rd,
	input wire i_flag_clr,
	input wire [`TCB_W-1:0] i_wdata,
	// state
	output reg [`TCB_W-1:0] o_value,
	output reg [`TCB_W-1:0] o_staging,
	output reg o_staging_full,
	output reg o_flag,
	output reg o_match_ev,
	output reg o_err
);
	wire live = (PRESENT != 0);
	wire cap = live & i_capture_mode & i_enable & i_capture;
	wire drain = o_flag & ~i_rd;
	wire move = live & i_capture_mode & o_staging_full & ~drain;
	wire match = live & ~i_capture_mode & i_enable & (i_cnt == o_value);
	always @(posedge i_sys_clk) begin
		if (i_rst | ~live) begin
			o_value <= `TCB_ZERO;
			o_staging <= `TCB_ZERO;
			o_staging_full <= 1'b0;
			o_flag <= 1'b0;
			o_match_ev <= 1'b0;
			o_err <= 1'b0;
		end else begin
			o_match_ev <= match;
			o_err <= cap & o_staging_full & drain;
			if (i_capture_mode) begin
				if (move) begin
					o_value <= o_staging;
					o_flag <= 1'b1;
				end else if (i_rd | i_flag_clr) begin
					o_flag <= 1'b0;
				end
				if (cap & ~(o_staging_full & drain)) begin
					o_staging <= i_cnt;
					o_staging_full <= 1'b1;
				end else if (move) begin
					o_staging_full <= 1'b0;
				end
			end else begin
				if (match) begin
					o_flag <= 1'b1;
				end else if (i_flag_clr) begin
					o_flag <= 1'b0;
				end
				if (i_stg_wr) begin
					o_staging <= i_wdata;
					o_staging_full <= i_double_buf;
				end else if (i_update) begin
					o_staging_full <= 1'b0;
				end
				if (i_double_buf & i_update & o_staging_full) begin
					o_value <= o_staging;
				end
				if (i_stg_wr & ~i_double_buf) begin
					o_value <= i_wdata;
				end
			end
			if (i_wr) begin
				o_value <= i_wdata;
			end
		end
	end
endmodule

// ---- hw/tcb_base.v ----
/*
 16-bit timer/counter base: count source selection, up/down counting,
 cycle length double buffering, split mode and compare/capture channels.
 assumes software strobes are one-cycle pulses synchronous to i_sys_clk
 and event channels are synchronous levels or pulses.
*/
`timescale 1ns/100ps
`include "tcb_regs.vh"
module tcb_base #(
	parameter TYPE0 = 1
) (
	// clock and reset
	input wire i_sys_clk,
	input wire i_rst,
	// configuration
	input wire [`TCB_CSEL_W-1:0] i_count_source_select,
	input wire [1:0] i_event_response_kind,
	input wire [2:0] i_event_channel_choice,
	input wire i_dir_down,
	input wire i_double_buf,
	input wire i_top_from_first_channel,
	input wire i_split,
	input wire [`TCB_NCH-1:0] i_ch_enable,
	// event channels
	input wire [`TCB_EV_N-1:0] i_ev,
	// software writes and reads
	input wire [`TCB_W-1:0] i_wdata,
	input wire i_counter_value_wr,
	input wire i_cycle_length_wr,
	input wire i_cycle_length_staging_wr,
	input wire [`TCB_NCH-1:0] i_ch_wr,
	input wire [`TCB_NCH-1:0] i_ch_staging_wr,
	input wire [`TCB_NCH-1:0] i_ch_rd,
	input wire [`TCB_NCH-1:0] i_ch_flag_clr,
	// counter state
	output reg [`TCB_W-1:0] o_counter_value,
	output reg [`TCB_W-1:0] o_cycle_length,
	output reg [`TCB_W-1:0] o_cycle_length_staging,
	output reg o_cycle_staging_full_flag,
	output reg o_overflow_ev,
	output reg o_split_high_overflow_ev,
	output reg o_refresh,
	// channel state
	output wire [`TCB_NCH*`TCB_W-1:0] o_channel_match_value,
	output wire [`TCB_NCH*`TCB_W-1:0] o_channel_staging,
	output wire [`TCB_NCH-1:0] o_staging_full_flag,
	output wire [`TCB_NCH-1:0] o_ch_flag,
	output wire [`TCB_NCH-1:0] o_ch_match_ev,
	output wire [`TCB_NCH-1:0] o_capture_err
);
	localparam NCH = (TYPE0 != 0) ? 4 : 2;

	// prescaler
	wire [`TCB_PSC_N-1:0] psc_tick;
	tcb_prescaler u_psc (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.o_tick(psc_tick)
	);

	// count source
	reg src_tick;
	reg [3:0] psc_idx;
	always @* begin
		psc_idx = i_count_source_select[3:0] - 4'h1;
		src_tick = 1'b0;
		if (i_count_source_select == `TCB_CSEL_OFF) begin
			src_tick = 1'b0;
		end else if (i_count_source_select[`TCB_CSEL_EV_BIT]) begin
			src_tick = i_ev[i_count_source_select[2:0]];
		end else if (i_count_source_select <= `TCB_CSEL_PSC_LAST) begin
			src_tick = psc_tick[psc_idx];
		end
	end

	// event action counting
	wire [2:0] ev_dir_idx = i_event_channel_choice + 3'h1;
	wire updown = (i_event_response_kind == `TCB_EVR_UPDOWN);
	wire capture_mode = (i_event_response_kind == `TCB_EVR_CAPTURE);
	wire ev_enable = i_ev[i_event_channel_choice];
	// event source select is the software's job here
	wire tick = src_tick & (~updown | ev_enable);
	wire down = updown ? ~i_ev[ev_dir_idx] : i_dir_down;

	// sequence peak and floor
	wire [`TCB_W-1:0] ch0_value = o_channel_match_value[`TCB_W-1:0];
	wire [`TCB_W-1:0] top = i_top_from_first_channel ?
		ch0_value : o_cycle_length;
	wire at_floor = (o_counter_value == `TCB_ZERO);
	wire at_max = (o_counter_value == `TCB_MAX);
	wire at_top = (o_counter_value == top);
	wire split_on = i_split & (TYPE0 != 0);

	// split halves
	wire [`TCB_HALF-1:0] lo = o_counter_value[`TCB_HALF-1:0];
	wire [`TCB_HALF-1:0] hi = o_counter_value[`TCB_W-1:`TCB_HALF];
	wire [`TCB_HALF-1:0] lo_top = o_cycle_length[`TCB_HALF-1:0];
	wire [`TCB_HALF-1:0] hi_top = o_cycle_length[`TCB_W-1:`TCB_HALF];

	// next counter value
	reg [`TCB_W-1:0] cnt_d;
	reg [`TCB_HALF-1:0] lo_d;
	reg [`TCB_HALF-1:0] hi_d;
	reg ovf_d;
	reg hi_ovf_d;
	always @* begin
		cnt_d = o_counter_value;
		lo_d = lo;
		hi_d = hi;
		ovf_d = 1'b0;
		hi_ovf_d = 1'b0;
		if (tick & split_on) begin
			if (down) begin
				lo_d = (lo == `TCB_BZERO) ? lo_top : lo - 8'h01;
				hi_d = (hi == `TCB_BZERO) ? hi_top : hi - 8'h01;
				ovf_d = (lo == `TCB_BZERO);
				hi_ovf_d = (hi == `TCB_BZERO);
			end else begin
				lo_d = (lo == lo_top) ? `TCB_BZERO : lo + 8'h01;
				hi_d = (hi == hi_top) ? `TCB_BZERO : hi + 8'h01;
				ovf_d = (lo == lo_top) | (lo == `TCB_BMAX);
				hi_ovf_d = (hi == hi_top) | (hi == `TCB_BMAX);
			end
			cnt_d = {hi_d, lo_d};
		end else if (tick & down) begin
			if (at_floor) begin
				cnt_d = top;
				ovf_d = 1'b1;
			end else begin
				cnt_d = o_counter_value - 16'h0001;
			end
		end else if (tick) begin
			if (at_top | at_max) begin
				cnt_d = `TCB_ZERO;
				ovf_d = 1'b1;
			end else begin
				cnt_d = o_counter_value + 16'h0001;
			end
		end
		if (i_counter_value_wr) begin
			cnt_d = i_wdata;
		end
	end

	// refresh point: the wrap at the peak or reload at the floor
	wire update = ovf_d & ~i_counter_value_wr;

	// counter and cycle length registers
	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_counter_value <= `TCB_ZERO;
			o_cycle_length <= `TCB_MAX;
			o_cycle_length_staging <= `TCB_ZERO;
			o_cycle_staging_full_flag <= 1'b0;
			o_overflow_ev <= 1'b0;
			o_split_high_overflow_ev <= 1'b0;
			o_refresh <= 1'b0;
		end else begin
			o_counter_value <= cnt_d;
			o_overflow_ev <= ovf_d;
			o_split_high_overflow_ev <= hi_ovf_d;
			o_refresh <= update;
			if (i_cycle_length_staging_wr) begin
				o_cycle_length_staging <= i_wdata;
				o_cycle_staging_full_flag <= i_double_buf;
			end else if (update) begin
				o_cycle_staging_full_flag <= 1'b0;
			end
			if (i_double_buf & update & o_cycle_staging_full_flag) begin
				o_cycle_length <= o_cycle_length_staging;
			end
			if (i_cycle_length_staging_wr & ~i_double_buf) begin
				o_cycle_length <= i_wdata;
			end
			if (i_cycle_length_wr) begin
				o_cycle_length <= i_wdata;
			end
		end
	end

	// compare/capture channels
	genvar g;
	generate
		for (g = 0; g < `TCB_NCH; g = g + 1) begin : gen_ch
			localparam [31:0] CH_NUM = g;
			wire [2:0] cap_idx = i_event_channel_choice + CH_NUM[2:0];
			tcb_channel #(
				.PRESENT(g < NCH)
			) u_ch (
				.i_sys_clk(i_sys_clk),
				.i_rst(i_rst),
				.i_capture_mode(capture_mode),
				.i_double_buf(i_double_buf),
				.i_enable(i_ch_enable[g]),
				.i_cnt(o_counter_value),
				.i_update(update),
				.i_capture(i_ev[cap_idx]),
				.i_wr(i_ch_wr[g]),
				.i_stg_wr(i_ch_staging_wr[g]),
				.i_rd(i_ch_rd[g]),
				.i_flag_clr(i_ch_flag_clr[g]),
				.i_wdata(i_wdata),
				.o_value(o_channel_match_value[g*`TCB_W +: `TCB_W]),
				.o_staging(o_channel_staging[g*`TCB_W +: `TCB_W]),
				.o_staging_full(o_staging_full_flag[g]),
				.o_flag(o_ch_flag[g]),
				.o_match_ev(o_ch_match_ev[g]),
				.o_err(o_capture_err[g])
			);
		end
	endgenerate
endmodule

// ---- verif/tcb_sva.sv ----
/* assertions on the tcb_base ports, bound to the block.
 assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module tcb_sva (
	input wire i_sys_clk, i_rst, i_dir_down, i_double_buf, i_split,
	input wire i_top_from_first_channel, i_counter_value_wr,
	input wire i_cycle_length_wr, i_cycle_length_staging_wr,
	input wire o_cycle_staging_full_flag, o_overflow_ev, o_refresh,
	input wire o_split_high_overflow_ev,
	input wire [4:0] i_count_source_select,
	input wire [1:0] i_event_response_kind,
	input wire [2:0] i_event_channel_choice,
	input wire [7:0] i_ev,
	input wire [3:0] o_staging_full_flag, o_ch_flag,
	input wire [15:0] i_wdata, o_counter_value, o_cycle_length
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// plain counting on the undivided tick, no writes
	wire norm = i_count_source_select == 5'h01 && !i_split && !i_double_buf
		&& i_event_response_kind == 2'h0 && !i_top_from_first_channel
		&& !(i_counter_value_wr | i_cycle_length_wr)
		&& !i_cycle_length_staging_wr;
	rst_clear_a:
		assert property ($past(i_rst) |-> o_counter_value == 16'h0000
			&& !o_cycle_staging_full_flag
			&& (o_staging_full_flag | o_ch_flag) == 4'h0)
		else $error("reset state wrong");
	no_source_a:
		assert property (i_count_source_select == 5'h00 && !i_counter_value_wr
			|=> $stable(o_counter_value)) else $error("counted with no source");
	cnt_write_a:
		assert property (i_counter_value_wr
			|=> o_counter_value == $past(i_wdata)) else $error("count write lost");
	len_write_a:
		assert property (i_cycle_length_wr
			|=> o_cycle_length == $past(i_wdata)) else $error("cycle write lost");
	stg_full_a:
		assert property (i_double_buf && i_cycle_length_staging_wr
			|=> o_cycle_staging_full_flag) else $error("staging flag not set");
	stg_hold_a:
		assert property (!o_refresh && $past(i_double_buf)
			&& !$past(i_cycle_length_wr) |-> $stable(o_cycle_length))
		else $error("cycle changed off refresh");
	up_wrap_a:
		assert property (norm && !i_dir_down && o_counter_value == o_cycle_length
			|=> o_counter_value == 16'h0000 && o_overflow_ev)
		else $error("no wrap at peak");
	down_load_a:
		assert property (norm && i_dir_down && o_counter_value == 16'h0000
			|=> o_counter_value == $past(o_cycle_length) && o_refresh)
		else $error("no reload at floor");
	ud_hold_a:
		assert property (i_event_response_kind == 2'h1 && !i_counter_value_wr
			&& !i_ev[i_event_channel_choice] |=> $stable(o_counter_value))
		else $error("counted while disabled");
	split_hi_a:
		assert property (i_split && i_count_source_select == 5'h01
			&& i_event_response_kind == 2'h0 && !i_dir_down
			&& !i_counter_value_wr
			&& o_counter_value[15:8] == o_cycle_length[15:8]
			|=> o_split_high_overflow_ev && o_counter_value[15:8] == 8'h00)
		else $error("high half did not wrap");
endmodule
bind tcb_base tcb_sva tcb_sva_i (.*);

// ---- verif/tcb_evsys.sv ----
/* event system stand-in: held levels plus random pulses.
 assumes requests change at falling edges of i_sys_clk. */
`timescale 1ns/100ps
module tcb_evsys (
	// clock and requests
	input wire i_sys_clk,
	input wire [7:0] i_lvl,
	input wire [7:0] i_rnd,
	// event channels
	output reg [7:0] o_ev
);
	integer seed = 41;
	reg [7:0] nxt;
	initial o_ev = 8'h00;
	// direction channel stays a held level
	always @(posedge i_sys_clk) begin
		nxt = i_lvl | (i_rnd & 8'($random(seed)));
		@(negedge i_sys_clk);
		o_ev <= nxt;
	end
endmodule

// ---- verif/test_timer_counter_base.sv ----
/* self-checking bench for tcb_base: wrap notes queued by the driver.
 assumes tcb_evsys and tcb_sva are compiled first. */
`timescale 1ns/100ps
module test_timer_counter_base;
	typedef struct {int gap; logic [15:0] cnt;} tcb_note_t;
	tcb_note_t nq[$], n;
	logic i_sys_clk = 0, i_rst = 1, i_dir_down = 0, i_double_buf = 0;
	logic i_split = 0, i_top_from_first_channel = 0;
	logic i_counter_value_wr = 0, i_cycle_length_wr = 0;
	logic i_cycle_length_staging_wr = 0;
	logic [4:0] i_count_source_select = 0;
	logic [1:0] i_event_response_kind = 0;
	logic [2:0] i_event_channel_choice = 0;
	logic [15:0] i_wdata = 0;
	logic [3:0] i_ch_enable = 0, i_ch_wr = 0, i_ch_staging_wr = 0;
	logic [3:0] i_ch_rd = 0, i_ch_flag_clr = 0;
	logic [7:0] lvl = 0, rnd = 0;
	wire [7:0] i_ev;
	wire [15:0] o_counter_value, o_cycle_length, o_cycle_length_staging;
	wire [63:0] o_channel_match_value, o_channel_staging;
	wire [3:0] o_staging_full_flag, o_ch_flag, o_ch_match_ev, o_capture_err;
	wire o_cycle_staging_full_flag, o_overflow_ev, o_split_high_overflow_ev;
	wire o_refresh;
	int bad_count = 0, compares = 0, gap = 0;
	int errs = 0, mev = 0;
	tcb_base tcb_base_i (.*);
	tcb_evsys tcb_evsys_i (.i_sys_clk(i_sys_clk), .i_lvl(lvl), .i_rnd(rnd),
		.o_ev(i_ev));
	always #50 i_sys_clk = ~i_sys_clk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// w: 0 count, 1 cycle, 2 staging, 3 ch1, 4 ch1 staging, 5 read ch0
	// w: 6 clear ch0 flag
	task wr(input int w, input logic [15:0] d);
		@(negedge i_sys_clk);
		i_wdata = d;
		i_counter_value_wr = w == 0;
		i_cycle_length_wr = w == 1;
		i_cycle_length_staging_wr = w == 2;
		i_ch_wr[1] = w == 3;
		i_ch_staging_wr[1] = w == 4;
		i_ch_rd[0] = w == 5;
		i_ch_flag_clr[0] = w == 6;
		@(negedge i_sys_clk);
		{i_counter_value_wr, i_cycle_length_wr, i_cycle_length_staging_wr} = 0;
		{i_ch_wr, i_ch_staging_wr, i_ch_rd, i_ch_flag_clr} = 0;
	endtask
	// two wraps expected, the second g cycles after the first
	task wrap2(input int g, input logic [15:0] c, input int lim);
		repeat (2) @(negedge i_sys_clk);
		nq.push_back('{0, c});
		nq.push_back('{g, c});
		while (nq.size() > 0 && lim > 0) begin
			@(posedge i_sys_clk);
			lim--;
		end
		check(16'(nq.size()), 16'h0000);
		nq.delete();
		@(negedge i_sys_clk);
	endtask
	task cap(input logic [15:0] c);
		wr(0, c);
		lvl = 8'h10;
		@(negedge i_sys_clk);
		lvl = 8'h00;
		repeat (4) @(negedge i_sys_clk);
	endtask
	always @(posedge i_sys_clk) begin
		#1 gap++;
		if (o_capture_err[0])
			errs++;
		if (o_ch_match_ev[0])
			mev++;
		if (o_overflow_ev && nq.size() > 0) begin
			n = nq.pop_front();
			check(o_counter_value, n.cnt);
			check(o_refresh, 1);
			check(o_split_high_overflow_ev, i_split);
			if (n.gap > 0)
				check(16'(gap), 16'(n.gap));
		end
		if (o_overflow_ev)
			gap = 0;
	end
	initial begin
		#4000000;
		bad_count++;
		$display("ERROR %0t timeout", $time);
		complete_run;
	end
	initial begin
		repeat (4) @(negedge i_sys_clk);
		i_rst = 0;
		repeat (6) @(negedge i_sys_clk);
		check(o_counter_value, 16'h0000);
		check({o_cycle_staging_full_flag, o_staging_full_flag, o_ch_flag}, 0);
		wr(1, 16'h0001);
		check(o_cycle_length, 16'h0001);
		for (int k = 0; k < 11; k++) begin
			wr(0, 16'h0000);
			i_count_source_select = 5'(k + 1);
			wrap2(2 << k, 16'h0000, (8 << k) + 20);
		end
		i_count_source_select = 5'h01;
		i_double_buf = 1;
		wr(1, 16'h0007);
		wr(0, 16'h0000);
		wr(2, 16'h0003);
		check(o_cycle_staging_full_flag, 1);
		check(o_cycle_length, 16'h0007);
		check(o_cycle_length_staging, 16'h0003);
		wrap2(4, 16'h0000, 60);
		check(o_cycle_staging_full_flag, 0);
		i_double_buf = 0;
		wr(0, 16'hfff0);
		wr(1, 16'h0004);
		check(o_counter_value[15:4], 12'hfff);
		wrap2(0, 16'h0000, 40);
		i_dir_down = 1;
		wrap2(5, 16'h0004, 40);
		i_dir_down = 0;
		i_count_source_select = 5'h12;
		i_event_response_kind = 1;
		i_event_channel_choice = 2;
		lvl = 8'h0c;
		wrap2(5, 16'h0000, 60);
		lvl = 8'h04;
		wrap2(5, 16'h0004, 60);
		lvl = 8'h00;
		rnd = 8'h04;
		wrap2(0, 16'h0004, 400);
		rnd = 8'h00;
		lvl = 8'h08;
		wr(0, 16'h0002);
		repeat (5) @(negedge i_sys_clk);
		check(o_counter_value, 16'h0002);
		wr(3, 16'h5a5a);
		check(o_channel_match_value[31:16], 16'h5a5a);
		wr(4, 16'h1234);
		check(o_channel_staging[31:16], 16'h1234);
		i_count_source_select = 5'h00;
		i_event_response_kind = 2;
		i_event_channel_choice = 4;
		i_ch_enable = 4'h1;
		cap(16'h00aa);
		check(o_channel_match_value[15:0], 16'h00aa);
		check({o_ch_flag[0], o_staging_full_flag[0]}, 16'h0002);
		cap(16'h00bb);
		check({o_staging_full_flag[0], o_channel_staging[15:0]}, 17'h100bb);
		cap(16'h00cc);
		check(errs, 1);
		check(o_channel_staging[15:0], 16'h00bb);
		wr(5, 16'h0000);
		@(negedge i_sys_clk);
		check(o_channel_match_value[15:0], 16'h00bb);
		i_event_response_kind = 0;
		i_top_from_first_channel = 1;
		wr(6, 16'h0000);
		check(o_ch_flag[0], 0);
		wr(0, 16'h0000);
		i_count_source_select = 5'h01;
		mev = 0;
		wrap2(188, 16'h0000, 420);
		check(o_ch_flag[0], 1);
		check(mev, 2);
		i_top_from_first_channel = 0;
		i_split = 1;
		wr(1, 16'h0404);
		wr(0, 16'h0000);
		wrap2(5, 16'h0000, 40);
		complete_run;
	end
endmodule
